// File: src/gpc_defs.svh
/*
   register map, field positions, reset values and widths of the port pin control block.
   assumes inclusion by bare name from the package and the design modules.
*/
`ifndef GPC_DEFS_SVH
`define GPC_DEFS_SVH

// word address: [4:3] selects port A/B/C or the system group, [2:0] the register
`define GPC_ADDR_W        5
`define GPC_DATA_W        32
`define GPC_PORT_W        8
`define GPC_NPORT         3
`define GPC_NIRQ          2
`define GPC_IRQ_PINS      4
`define GPC_GRP_SYS       2'h3

`define GPC_REG_DATA      3'h0
`define GPC_REG_DIR       3'h1
`define GPC_REG_PULL      3'h2
`define GPC_REG_SLEW      3'h3
`define GPC_REG_DRIVE     3'h4
`define GPC_REG_IRQ_SC    3'h5
`define GPC_REG_IRQ_PS    3'h6
`define GPC_REG_IRQ_ES    3'h7
`define GPC_REG_GANG      3'h0
`define GPC_REG_PWR       3'h1

// pin_irq_status_control fields
`define GPC_SC_MODE       0
`define GPC_SC_IE         1
`define GPC_SC_ACK        2
`define GPC_SC_FLAG       3
// power_mgmt_status_control_two fields
`define GPC_PWR_ACK       2
`define GPC_PWR_FLAG      3

// gang control: bit 0 enables, bits 7:1 select pins
`define GPC_GANG_EN       0
`define GPC_LEAD_PORT     2
`define GPC_LEAD_BIT      0
`define GPC_PORT_A        0
`define GPC_PORT_B        1
`define GPC_PORT_C        2

`define GPC_RST_BYTE      8'h00
`define GPC_RST_WORD      32'h0000_0000
`define GPC_IRQ_MASK      8'h0F

`endif

// File: src/gpc_pkg.sv
/*
   types shared by the port pin control modules.
   assumes gpc_defs.svh is on the include path.
*/
`include "gpc_defs.svh"

package gpc_pkg;

   typedef logic [`GPC_PORT_W-1:0]                  gpc_byte_t;
   typedef logic [`GPC_NPORT-1:0][`GPC_PORT_W-1:0]  gpc_ports_t;
   typedef logic [`GPC_NIRQ-1:0][`GPC_PORT_W-1:0]   gpc_irqb_t;

   typedef struct packed {
      gpc_ports_t              data;
      gpc_ports_t              dir;
      gpc_ports_t              pull;
      gpc_ports_t              slew;
      gpc_ports_t              drive;
      gpc_irqb_t               pin_sel;
      gpc_irqb_t               edge_sel;
      logic [`GPC_NIRQ-1:0]    ie;
      logic [`GPC_NIRQ-1:0]    mode;
      gpc_byte_t               gang;
      logic                    gang_done;
      logic                    ppd_flag;
      gpc_ports_t              sync1;
      gpc_ports_t              sync2;
      logic                    waitreq;
      logic [`GPC_DATA_W-1:0]  rdata;
      gpc_ports_t              pin_out;
      gpc_ports_t              pin_oe;
      gpc_ports_t              pull_en;
      gpc_ports_t              pull_dn;
      gpc_ports_t              slew_en;
      gpc_ports_t              high_drive;
      logic [`GPC_NIRQ-1:0]    irq;
      logic                    wake;
   } gpc_state_s;

   typedef struct packed {
      gpc_byte_t               prev_asserted;
      logic                    flag;
   } gpc_irq_state_s;

endpackage : gpc_pkg

// File: src/gpc_irq_if.sv
/*
   carrier between the pin control top and one pin interrupt unit.
   assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface gpc_irq_if;
   gpc_pkg::gpc_byte_t   level;
   gpc_pkg::gpc_byte_t   pin_sel;
   gpc_pkg::gpc_byte_t   edge_sel;
   logic                 mode;
   logic                 ack;
   logic                 flag;
   logic                 any_asserted;

   modport port_side (output level, output pin_sel, output edge_sel, output mode,
                      output ack, input flag, input any_asserted);
   modport unit      (input level, input pin_sel, input edge_sel, input mode,
                      input ack, output flag, output any_asserted);
endinterface : gpc_irq_if

`default_nettype wire

// File: src/gpc_pin_irq.sv
/*
   one pin interrupt unit: detection of edges or levels on the enabled pins of one port.
   assumes level is already synchronised to core_clk.
*/
`timescale 1ns/1ps
`default_nettype none

module gpc_pin_irq (
   input  wire logic    core_clk,
   input  wire logic    nrst,
   gpc_irq_if.unit      irq
);

   gpc_pkg::gpc_irq_state_s   st;
   gpc_pkg::gpc_irq_state_s   nxt_st;
   gpc_pkg::gpc_byte_t        asserted;
   gpc_pkg::gpc_byte_t        edges;
   logic                      set;

   always_comb
   begin
      nxt_st   = st;
      // low level / falling edge when edge select is 0, high / rising when 1
      asserted = irq.pin_sel & ~(irq.level ^ irq.edge_sel);
      // an edge needs a deasserted sample the cycle before
      edges    = asserted & ~st.prev_asserted;
      if (irq.mode)
      begin
         set = |asserted;
      end
      else
      begin
         // another pin already asserted blocks a new request
         set = (|edges) && !(|(st.prev_asserted & irq.pin_sel));
      end
      nxt_st.prev_asserted = asserted;
      if (set)
      begin
         nxt_st.flag = 1'b1;
      end
      else if (irq.ack && !(irq.mode && (|asserted)))
      begin
         nxt_st.flag = 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st <= '0;
      end
      else
      begin
         st <= nxt_st;
      end
   end

   assign irq.flag         = st.flag;
   assign irq.any_asserted = |st.prev_asserted;

endmodule : gpc_pin_irq

`default_nettype wire

// File: src/gpc_pin_ctrl.sv
/*
   port pin control top: pull, slew, drive, ganged output, two pin interrupt units,
   stop mode holding, and an Avalon-MM slave with waitrequest for all registers.
   assumes every input except pin_in comes from logic on core_clk; pin_in is asynchronous.
*/
// Chosen here: the address map and register access over Avalon-MM.
//
// Contract
// - each pin has a pull enable bit turning on its pull device
// - pull off while pin drives out, by direction or peripheral, or analog owns it
// - slew enable limits transition rate, ignored while pin is an input
// - drive select bit chooses high or low drive strength
// - gang control register takes one write: gang enable plus seven pin selects
// - selected gang pins are outputs with lead pin data, drive and slew
// - gang select bits 7..1 map to B5,B4,B3,B2,C3,C2,C1; bit 0 lead C0
// - gang enable forces the lead pin to output whatever its direction bit
// - gang output beats digital peripherals; analog function beats gang output
// - pins 3..0 of ports A and B are interrupt and wake sources
// - each interrupt pin has its own pin enable bit
// - per port mode bit: edge only or edge and level
// - per pin edge select picks falling/low or rising/high
// - edges detected synchronously, one bus cycle sample to the next
// - an edge needs a prior deasserted sample
// - edge mode: edge sets flag, interrupt if enabled, ack write clears
// - edge mode: no new request while another enabled pin is asserted
// - level mode: ack clears flag only when all enabled inputs deasserted
// - with pull enabled, edge select 0 means pull-up, 1 pull-down; here pull-down also needs the pin's interrupt pin enable bit
// - partial power-down stop holds pin latches; software checks flag, then acks
// - retained-logic stop preserves all pin state, function resumes at once
// - recovery flag reads 1 only after partial power-down stop recovery
// - after reset: peripherals off, inputs, slew, high drive, pulls disabled
//
`timescale 1ns/1ps
`default_nettype none
`include "gpc_defs.svh"

module gpc_pin_ctrl (
   input  wire logic                    core_clk,
   input  wire logic                    nrst,
   input  wire logic [`GPC_ADDR_W-1:0]  avs_address,
   input  wire logic                    avs_read,
   input  wire logic                    avs_write,
   input  wire logic [`GPC_DATA_W-1:0]  avs_writedata,
   input  wire logic [3:0]              avs_byteenable,
   output logic [`GPC_DATA_W-1:0]       avs_readdata,
   output logic                         avs_waitrequest,
   input  wire gpc_pkg::gpc_ports_t     pin_in,
   input  wire gpc_pkg::gpc_ports_t     periph_en,
   input  wire gpc_pkg::gpc_ports_t     periph_oe,
   input  wire gpc_pkg::gpc_ports_t     periph_out,
   input  wire gpc_pkg::gpc_ports_t     analog_en,
   input  wire logic                    partial_power_down_stop,
   input  wire logic                    ppd_recovered,
   output gpc_pkg::gpc_ports_t          pin_out,
   output gpc_pkg::gpc_ports_t          pin_oe,
   output gpc_pkg::gpc_ports_t          pull_en,
   output gpc_pkg::gpc_ports_t          pull_dn,
   output gpc_pkg::gpc_ports_t          slew_en,
   output gpc_pkg::gpc_ports_t          high_drive,
   output logic [`GPC_NIRQ-1:0]         port_irq,
   output logic                         pin_wake
);

   gpc_pkg::gpc_state_s    st;
   gpc_pkg::gpc_state_s    nxt_st;
   gpc_pkg::gpc_ports_t    in_level;
   gpc_pkg::gpc_ports_t    gang_pin;
   gpc_pkg::gpc_ports_t    eff_oe;
   gpc_pkg::gpc_ports_t    eff_out;
   gpc_pkg::gpc_ports_t    eff_slew;
   gpc_pkg::gpc_ports_t    eff_drive;
   logic [`GPC_NIRQ-1:0]   ack_pulse;
   logic [`GPC_NIRQ-1:0]   flags;
   logic [1:0]             grp;
   logic [2:0]             reg_sel;
   logic                   req;
   logic                   do_write;
   logic                   do_read_prep;
   logic                   lane0;
   logic [`GPC_PORT_W-1:0] wbyte;
   logic [`GPC_PORT_W-1:0] rbyte;
   logic                   lead_data;
   logic                   lead_slew;
   logic                   lead_drive;
   logic                   gang_on;

   gpc_irq_if   irq_a ();
   gpc_irq_if   irq_b ();

   // pin interrupt units for ports A and B
   gpc_pin_irq u_irq_a (
      .core_clk (core_clk),
      .nrst     (nrst),
      .irq      (irq_a)
   );

   gpc_pin_irq u_irq_b (
      .core_clk (core_clk),
      .nrst     (nrst),
      .irq      (irq_b)
   );

   // bus decode
   assign grp          = avs_address[4:3];
   assign reg_sel      = avs_address[2:0];
   assign req          = avs_read || avs_write;
   assign do_write     = avs_write && !st.waitreq;
   assign do_read_prep = avs_read && st.waitreq;
   assign lane0        = avs_byteenable[0];
   assign wbyte        = avs_writedata[`GPC_PORT_W-1:0];

   // analog pins have their input buffer off and read as 0
   assign in_level = st.sync2 & ~analog_en;

   // lead pin controls for the gang
   assign gang_on    = st.gang[`GPC_GANG_EN];
   assign lead_data  = st.data[`GPC_LEAD_PORT][`GPC_LEAD_BIT];
   assign lead_slew  = st.slew[`GPC_LEAD_PORT][`GPC_LEAD_BIT];
   assign lead_drive = st.drive[`GPC_LEAD_PORT][`GPC_LEAD_BIT];

   always_comb
   begin
      gang_pin = '0;
      if (gang_on)
      begin
         gang_pin[`GPC_PORT_B][5] = st.gang[7];
         gang_pin[`GPC_PORT_B][4] = st.gang[6];
         gang_pin[`GPC_PORT_B][3] = st.gang[5];
         gang_pin[`GPC_PORT_B][2] = st.gang[4];
         gang_pin[`GPC_PORT_C][3] = st.gang[3];
         gang_pin[`GPC_PORT_C][2] = st.gang[2];
         gang_pin[`GPC_PORT_C][1] = st.gang[1];
         gang_pin[`GPC_LEAD_PORT][`GPC_LEAD_BIT] = 1'b1;
      end
   end

   // per pin output path: analog over gang over peripheral over port
   always_comb
   begin
      for (int p = 0; p < `GPC_NPORT; p++)
      begin
         for (int b = 0; b < `GPC_PORT_W; b++)
         begin
            if (analog_en[p][b])
            begin
               eff_oe[p][b]    = 1'b0;
               eff_out[p][b]   = 1'b0;
               eff_slew[p][b]  = 1'b0;
               eff_drive[p][b] = 1'b0;
            end
            else if (gang_pin[p][b])
            begin
               eff_oe[p][b]    = 1'b1;
               eff_out[p][b]   = lead_data;
               eff_slew[p][b]  = lead_slew;
               eff_drive[p][b] = lead_drive;
            end
            else if (periph_en[p][b])
            begin
               eff_oe[p][b]    = periph_oe[p][b];
               eff_out[p][b]   = periph_out[p][b];
               eff_slew[p][b]  = st.slew[p][b];
               eff_drive[p][b] = st.drive[p][b];
            end
            else
            begin
               eff_oe[p][b]    = st.dir[p][b];
               eff_out[p][b]   = st.data[p][b];
               eff_slew[p][b]  = st.slew[p][b];
               eff_drive[p][b] = st.drive[p][b];
            end
         end
      end
   end

   // interrupt unit connections, only pins 3..0 are interrupt capable
   assign irq_a.level    = in_level[`GPC_PORT_A];
   assign irq_a.pin_sel  = st.pin_sel[`GPC_PORT_A] & `GPC_IRQ_MASK;
   assign irq_a.edge_sel = st.edge_sel[`GPC_PORT_A];
   assign irq_a.mode     = st.mode[`GPC_PORT_A];
   assign irq_a.ack      = ack_pulse[`GPC_PORT_A];
   assign irq_b.level    = in_level[`GPC_PORT_B];
   assign irq_b.pin_sel  = st.pin_sel[`GPC_PORT_B] & `GPC_IRQ_MASK;
   assign irq_b.edge_sel = st.edge_sel[`GPC_PORT_B];
   assign irq_b.mode     = st.mode[`GPC_PORT_B];
   assign irq_b.ack      = ack_pulse[`GPC_PORT_B];
   assign flags          = {irq_b.flag, irq_a.flag};

   // acknowledge strobes from writes to the status/control registers
   always_comb
   begin
      ack_pulse = '0;
      for (int q = 0; q < `GPC_NIRQ; q++)
      begin
         if (do_write && lane0 && (grp == q[1:0]) && (reg_sel == `GPC_REG_IRQ_SC))
         begin
            ack_pulse[q] = wbyte[`GPC_SC_ACK];
         end
      end
   end

   // read mux
   always_comb
   begin
      rbyte = `GPC_RST_BYTE;
      if (grp == `GPC_GRP_SYS)
      begin
         case (reg_sel)
            `GPC_REG_GANG: rbyte = st.gang;
            `GPC_REG_PWR:  rbyte[`GPC_PWR_FLAG] = st.ppd_flag;
            default:       rbyte = `GPC_RST_BYTE;
         endcase
      end
      else
      begin
         case (reg_sel)
            `GPC_REG_DATA:  rbyte = (st.dir[grp] & st.data[grp]) | (~st.dir[grp] & in_level[grp]);
            `GPC_REG_DIR:   rbyte = st.dir[grp];
            `GPC_REG_PULL:  rbyte = st.pull[grp];
            `GPC_REG_SLEW:  rbyte = st.slew[grp];
            `GPC_REG_DRIVE: rbyte = st.drive[grp];
            `GPC_REG_IRQ_SC:
            begin
               if (grp != `GPC_PORT_C)
               begin
                  rbyte[`GPC_SC_FLAG] = flags[grp[0]];
                  rbyte[`GPC_SC_IE]   = st.ie[grp[0]];
                  rbyte[`GPC_SC_MODE] = st.mode[grp[0]];
               end
            end
            `GPC_REG_IRQ_PS: rbyte = (grp != `GPC_PORT_C) ? st.pin_sel[grp[0]] : `GPC_RST_BYTE;
            `GPC_REG_IRQ_ES: rbyte = (grp != `GPC_PORT_C) ? st.edge_sel[grp[0]] : `GPC_RST_BYTE;
            default:         rbyte = `GPC_RST_BYTE;
         endcase
      end
   end

   always_comb
   begin
      nxt_st = st;

      // two flip-flop synchroniser on the pins
      nxt_st.sync1 = pin_in;
      nxt_st.sync2 = st.sync1;

      // one wait cycle, then the access completes
      nxt_st.waitreq = !(req && st.waitreq);
      if (do_read_prep)
      begin
         nxt_st.rdata = {{(`GPC_DATA_W-`GPC_PORT_W){1'b0}}, rbyte};
      end

      // register writes, low byte lane carries all fields
      if (do_write && lane0)
      begin
         if (grp == `GPC_GRP_SYS)
         begin
            case (reg_sel)
               `GPC_REG_GANG:
               begin
                  if (!st.gang_done)
                  begin
                     nxt_st.gang      = wbyte;
                     nxt_st.gang_done = 1'b1;
                  end
               end
               `GPC_REG_PWR:
               begin
                  if (wbyte[`GPC_PWR_ACK])
                  begin
                     nxt_st.ppd_flag = 1'b0;
                  end
               end
               default: nxt_st.ppd_flag = st.ppd_flag;
            endcase
         end
         else
         begin
            case (reg_sel)
               `GPC_REG_DATA:  nxt_st.data[grp]  = wbyte;
               `GPC_REG_DIR:   nxt_st.dir[grp]   = wbyte;
               `GPC_REG_PULL:  nxt_st.pull[grp]  = wbyte;
               `GPC_REG_SLEW:  nxt_st.slew[grp]  = wbyte;
               `GPC_REG_DRIVE: nxt_st.drive[grp] = wbyte;
               `GPC_REG_IRQ_SC:
               begin
                  if (grp != `GPC_PORT_C)
                  begin
                     nxt_st.ie[grp[0]]   = wbyte[`GPC_SC_IE];
                     nxt_st.mode[grp[0]] = wbyte[`GPC_SC_MODE];
                  end
               end
               `GPC_REG_IRQ_PS:
               begin
                  if (grp != `GPC_PORT_C)
                  begin
                     nxt_st.pin_sel[grp[0]] = wbyte & `GPC_IRQ_MASK;
                  end
               end
               `GPC_REG_IRQ_ES:
               begin
                  if (grp != `GPC_PORT_C)
                  begin
                     nxt_st.edge_sel[grp[0]] = wbyte & `GPC_IRQ_MASK;
                  end
               end
               default: nxt_st.data = st.data;
            endcase
         end
      end

      // recovery event wins over a same-cycle acknowledge
      if (ppd_recovered)
      begin
         nxt_st.ppd_flag = 1'b1;
      end

      // interrupt requests and wake
      nxt_st.irq  = flags & st.ie;
      nxt_st.wake = |flags;

      // pin latches hold through partial power-down stop
      if (!partial_power_down_stop)
      begin
         nxt_st.pin_oe     = eff_oe;
         nxt_st.pin_out    = eff_out;
         nxt_st.slew_en    = eff_slew & eff_oe;
         nxt_st.high_drive = eff_drive;
         nxt_st.pull_en    = st.pull & ~eff_oe & ~analog_en;
         nxt_st.pull_dn    = '0;
         for (int q = 0; q < `GPC_NIRQ; q++)
         begin
            nxt_st.pull_dn[q] = st.pull[q] & ~eff_oe[q] & ~analog_en[q]
                                & st.pin_sel[q] & st.edge_sel[q];
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st         <= '0;
         st.waitreq <= 1'b1;
      end
      else
      begin
         st <= nxt_st;
      end
   end

   assign avs_readdata    = st.rdata;
   assign avs_waitrequest = st.waitreq;
   assign pin_out         = st.pin_out;
   assign pin_oe          = st.pin_oe;
   assign pull_en         = st.pull_en;
   assign pull_dn         = st.pull_dn;
   assign slew_en         = st.slew_en;
   assign high_drive      = st.high_drive;
   assign port_irq        = st.irq;
   assign pin_wake        = st.wake;

endmodule : gpc_pin_ctrl

`default_nettype wire

// File: tb/gpc_pin_ctrl_checker.sv
/*
   port assertions of the pin control top.
   assumes one clock domain and a one-wait-cycle bus answer.
*/
`timescale 1ns/1ps
`default_nettype none
module gpc_pin_ctrl_checker (
   input wire logic                avs_read,
   input wire logic                avs_write,
   input wire logic                avs_waitrequest,
   input wire logic [31:0]         avs_readdata,
   input wire logic                core_clk,
   input wire logic                nrst,
   input wire logic                partial_power_down_stop,
   input wire gpc_pkg::gpc_ports_t analog_en,
   input wire gpc_pkg::gpc_ports_t pin_out,
   input wire gpc_pkg::gpc_ports_t pin_oe,
   input wire gpc_pkg::gpc_ports_t pull_en,
   input wire gpc_pkg::gpc_ports_t pull_dn,
   input wire gpc_pkg::gpc_ports_t slew_en
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   property p_wait; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_wait: assert property (p_wait) else $error("no answer");
   property p_pulse; !avs_waitrequest |=> avs_waitrequest; endproperty
   a_pulse: assert property (p_pulse) else $error("wait low too long");
   property p_hi; !avs_waitrequest |-> avs_readdata[31:8] == 24'h0; endproperty
   a_hi: assert property (p_hi) else $error("upper read bits set");
   property p_pull; (pull_en & pin_oe) == 24'h0; endproperty
   a_pull: assert property (p_pull) else $error("pull on output");
   property p_slew; (slew_en & ~pin_oe) == 24'h0; endproperty
   a_slew: assert property (p_slew) else $error("slew on input");
   property p_an; !partial_power_down_stop |=> ((pin_oe | pull_en) & $past(analog_en)) == 24'h0; endproperty
   a_an: assert property (p_an) else $error("analog pin driven");
   property p_dn; (pull_dn & ~(pull_en & 24'h000F0F)) == 24'h0; endproperty
   a_dn: assert property (p_dn) else $error("stray pull-down");
   property p_hold; partial_power_down_stop |=> $stable(pin_out) && $stable(pin_oe); endproperty
   a_hold: assert property (p_hold) else $error("pins moved in stop");
endmodule : gpc_pin_ctrl_checker
bind gpc_pin_ctrl gpc_pin_ctrl_checker u_chk (.avs_read, .avs_write, .avs_waitrequest,
   .avs_readdata, .core_clk, .nrst, .partial_power_down_stop, .analog_en, .pin_out,
   .pin_oe, .pull_en, .pull_dn, .slew_en);
`default_nettype wire

// File: tb/gpc_pins_model.sv
/*
   board pins: device, board driver, pull device; bare pins wander.
   assumes the bench never drives a pin the device drives.
*/
`timescale 1ns/1ps
`default_nettype none
module gpc_pins_model (
   input  wire logic                core_clk,
   input  wire gpc_pkg::gpc_ports_t pin_out,
   input  wire gpc_pkg::gpc_ports_t pin_oe,
   input  wire gpc_pkg::gpc_ports_t pull_en,
   input  wire gpc_pkg::gpc_ports_t pull_dn,
   input  wire gpc_pkg::gpc_ports_t ext_oe,
   input  wire gpc_pkg::gpc_ports_t ext_val,
   output gpc_pkg::gpc_ports_t      pin_in
);
   gpc_pkg::gpc_ports_t tog = '0;
   always @(posedge core_clk) tog <= ~tog;
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val)
                 | (~pin_oe & ~ext_oe & ((pull_en & ~pull_dn) | (~pull_en & tog)));
endmodule : gpc_pins_model
`default_nettype wire

// File: tb/tb_gpc_pin_ctrl.sv
/*
   random and directed bench of the pin control top.
   assumes the pins model and checker are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_gpc_pin_ctrl;
   logic                core_clk = 0, nrst = 0, avs_read = 0, avs_write = 0, stp = 0, rec = 0;
   logic [4:0]          avs_address = '0;
   logic [31:0]         avs_writedata = '0, avs_readdata;
   logic                avs_waitrequest, pin_wake;
   logic [1:0]          port_irq;
   gpc_pkg::gpc_ports_t pe = '0, po = '0, pv = '0, an = '0, eo = '0, ox, pin_in;
   gpc_pkg::gpc_ports_t pin_out, pin_oe, pull_en, pull_dn, slew_en, high_drive;
   gpc_pkg::gpc_ports_t cfg [5];
   int                  bad_count = 0, total_checks = 0;
   always #5 core_clk = ~core_clk;
   gpc_pin_ctrl dut (.core_clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
      .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .pin_in, .periph_en(pe),
      .periph_oe(po), .periph_out(pv), .analog_en(an), .partial_power_down_stop(stp),
      .ppd_recovered(rec), .pin_out, .pin_oe, .pull_en, .pull_dn, .slew_en, .high_drive,
      .port_irq, .pin_wake);
   gpc_pins_model pins (.core_clk, .pin_out, .pin_oe, .pull_en, .pull_dn, .ext_oe(eo),
      .ext_val(24'h00FF00), .pin_in);
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [7:0] e = 0);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= {24'h0, d};
      avs_write <= w;
      avs_read <= !w;
      do
         @(posedge core_clk);
      while (avs_waitrequest !== 1'b0);
      if (!w)
         chk(avs_readdata[23:0], 24'(e));
      avs_write <= 0;
      avs_read <= 0;
   endtask : bus
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask : tick
   task automatic irq_is(input int i, input logic v);
      for (int n = 0; n < 12 && port_irq[i] !== v; n++)
         @(posedge core_clk);
      chk(24'(port_irq[i]), 24'(v));
   endtask : irq_is
   task automatic irq_init(input logic [4:0] g, input logic [7:0] es, input logic [7:0] sc);
      bus(1, g + 5'd5, 8'h00);
      bus(1, g + 5'd7, es);
      bus(1, g + 5'd2, 8'h0F);
      bus(1, g + 5'd1, 8'h00);
      bus(1, g + 5'd6, 8'h07);
      tick(4);
      bus(1, g + 5'd5, 8'h04);
      bus(1, g + 5'd5, sc);
   endtask : irq_init
   function automatic gpc_pkg::gpc_ports_t f_oe(input gpc_pkg::gpc_ports_t d);
      return ~an & ((pe & po) | (~pe & d));
   endfunction : f_oe
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : print_verdict
   initial
   begin
      #400000;
      bad_count++;
      print_verdict();
   end
   initial
   begin
      void'($urandom(33352));
      tick(16);
      nrst <= 1;
      @(posedge core_clk);
      chk(pin_oe | pull_en | slew_en | high_drive | pull_dn, 0);
      chk({port_irq, pin_wake, avs_waitrequest}, 1);
      bus(0, 5'd27, 0, 0);
      $display("reset done");
      for (int i = 0; i < 6; i++)
      begin
         for (int k = 0; k < 15; k++)
         begin
            cfg[k%5][k/5] = 8'($urandom);
            bus(1, 5'(8 * (k / 5) + k % 5), cfg[k%5][k/5]);
         end
         pe <= 24'($urandom);
         po <= 24'($urandom);
         pv <= 24'($urandom);
         an <= 24'($urandom & $urandom);
         tick(2);
         ox = f_oe(cfg[1]);
         chk(pin_oe, ox);
         chk(pull_en, cfg[2] & ~ox & ~an);
         chk(slew_en, cfg[3] & ox);
         chk(high_drive & ox, cfg[4] & ox);
         chk(pin_out & ox, ((pe & pv) | (~pe & cfg[0])) & ox);
      end
      pe <= '0;
      an <= '0;
      $display("pins done");
      irq_init(5'd0, 8'h00, 8'h02);
      eo <= 24'h000008;
      tick(8);
      chk(24'(port_irq), 0);
      eo <= 24'h000009;
      irq_is(0, 1);
      chk(24'(pin_wake), 1);
      bus(0, 5'd5, 0, 8'h0A);
      bus(1, 5'd5, 8'h06);
      irq_is(0, 0);
      eo <= 24'h00000B;
      tick(8);
      chk(24'(port_irq), 0);
      eo <= 24'h000008;
      tick(4);
      eo <= 24'h00000C;
      irq_is(0, 1);
      irq_init(5'd8, 8'h0F, 8'h03);
      chk(pull_dn, 24'h000700);
      eo <= 24'h000400;
      irq_is(1, 1);
      bus(1, 5'd13, 8'h07);
      tick(6);
      chk(24'(port_irq[1]), 1);
      eo <= '0;
      tick(6);
      bus(1, 5'd13, 8'h07);
      irq_is(1, 0);
      $display("irq done");
      rec <= 1;
      @(posedge core_clk);
      rec <= 0;
      bus(0, 5'd25, 0, 8'h08);
      bus(1, 5'd25, 8'h04);
      bus(0, 5'd25, 0, 0);
      stp <= 1;
      bus(1, 5'd1, 8'hFF);
      tick(3);
      chk(pin_oe[0], 0);
      stp <= 0;
      tick(3);
      chk(pin_oe[0], 8'hFF);
      $display("stop done");
      for (int k = 16; k < 21; k++)
         bus(1, 5'(k), 8'(k != 17));
      pe <= 24'h002000;
      bus(1, 5'd24, 8'hFF);
      bus(1, 5'd24, 8'h00);
      bus(0, 5'd24, 0, 8'hFF);
      chk(pin_oe & 24'h0F3C00, 24'h0F3C00);
      chk(pin_out & slew_en & high_drive & 24'h0F3C00, 24'h0F3C00);
      bus(1, 5'd16, 8'h00);
      an <= 24'h000400;
      tick(2);
      chk(pin_out & 24'h0F3C00, 0);
      chk(pin_oe & 24'h0F3C00, 24'h0F3800);
      $display("gang done");
      print_verdict();
   end
endmodule : tb_gpc_pin_ctrl
`default_nettype wire
